// ===== logic/aas_pkg.sv
package aas_pkg;
   // alarm status word bit positions
   localparam int OUT_FLAG_LSB  = 0;
   localparam int DISC_FLAG_LSB = 4;
   localparam int RATIO_USE_BIT = 8;
   localparam int RATIO_SET_BIT = 9;
   localparam int HOLD_SET_BIT  = 10;
   localparam int AVG_SET_BIT   = 11;
   localparam int ADJ_RANGE_BIT = 12;
   localparam int ADJ_CHAN_BIT  = 13;
   localparam int NVM_FAIL_BIT  = 14;
   localparam int ADJ_MODE_BIT  = 15;
   localparam logic [15:0] ALARM_RESET    = 16'h0000;
   localparam logic [15:0] ALARM_PLC_ONLY = 16'h8000;
   // word block placement
   localparam logic [15:0] BLOCK_BASE   = 16'h07D0;
   localparam logic [15:0] BLOCK_STRIDE = 16'h000A;
   localparam logic [15:0] ALARM_OFS    = 16'h0009;
   localparam logic [6:0]  UNIT_MAX     = 7'h5F;
   // initial setting limits
   localparam logic [15:0] HOLD_SET_MAX = 16'h0002;
   localparam logic [15:0] AVG_SET_MAX  = 16'h0006;
   localparam logic [3:0]  BCD_DIGIT_MAX = 4'h9;
   // output hold selections
   localparam logic [1:0]  HOLD_ZERO = 2'h0;
   localparam logic [1:0]  HOLD_LAST = 2'h1;
   localparam logic [1:0]  HOLD_FULL = 2'h2;
   localparam logic [15:0] OUT_FULL  = 16'h0FA0;
   localparam logic [15:0] DATA_ZERO = 16'h0000;
   // adjustment channel codes
   localparam logic [3:0]  CH_GRP_IN  = 4'h1;
   localparam logic [3:0]  CH_GRP_OUT = 4'h2;
   localparam logic [3:0]  CH_IDX_MIN = 4'h1;
   localparam logic [3:0]  CH_IDX_MAX = 4'h4;
   // timing
   localparam int CLK_MHZ   = 100;
   localparam int BLINK_MS  = 250;
   localparam int BLINK_CYC = BLINK_MS * 1000 * CLK_MHZ;
   localparam logic [1:0] INIT_WAIT = 2'h3;

   typedef enum logic [2:0] {
      ST_INIT     = 3'h0,
      ST_RUN      = 3'h1,
      ST_CFG_ERR  = 3'h2,
      ST_UNIT_ERR = 3'h3,
      ST_ADJ      = 3'h4,
      ST_ADJ_PLC  = 3'h5,
      ST_RESTART  = 3'h6
   } aas_state_t;

   typedef struct packed {
      logic        ratio_unused;
      logic [15:0] ratio_set;
      logic [15:0] hold_set;
      logic [15:0] avg_set;
   } aas_init_cfg_t;

   typedef struct packed {
      logic bus_err;
      logic mon_timeout;
      logic watchdog;
   } aas_host_flt_t;

   typedef logic [3:0][15:0] aas_word4_t;
endpackage

// ===== logic/aas_top.sv
`timescale 1ns/10ps
module aas_top #(
   parameter int unsigned BLINK_CYC = aas_pkg::BLINK_CYC
) (
   // clock and reset
   input  wire logic                  core_clk_i,
   input  wire logic                  rstn_i,
   // pins
   input  wire logic [6:0]            unit_no_pin_i,
   input  wire logic                  adj_switch_pin_i,
   // host control
   input  wire logic                  io_refresh_i,
   input  wire logic                  restart_i,
   input  wire logic                  host_run_i,
   input  wire logic                  commit_i,
   input  wire logic                  dup_unit_i,
   input  wire aas_pkg::aas_host_flt_t host_flt_i,
   input  wire aas_pkg::aas_init_cfg_t init_cfg_i,
   // channel conditions
   input  wire logic [3:0]            in_used_i,
   input  wire logic [3:0]            out_used_i,
   input  wire logic [3:0]            range_1to5_i,
   input  wire logic [3:0]            disc_i,
   input  wire logic [3:0]            out_range_err_i,
   input  wire aas_pkg::aas_word4_t   conv_data_i,
   input  wire aas_pkg::aas_word4_t   out_set_i,
   // adjustment
   input  wire logic [7:0]            adj_ch_i,
   input  wire logic                  adj_range_err_i,
   input  wire logic                  nvm_fail_i,
   // results
   output logic [15:0]                alarm_status_word_o,
   output logic [15:0]                word_base_o,
   output logic [15:0]                alarm_addr_o,
   output aas_pkg::aas_word4_t        in_data_o,
   output aas_pkg::aas_word4_t        out_value_o,
   output logic                       conv_run_o,
   // lamps
   output logic                       unit_error_lamp_o,
   output logic                       host_error_lamp_o,
   output logic                       adjust_lamp_o,
   output logic                       run_lamp_o
);
   aas_pkg::aas_state_t st_r, st_nxt;
   logic [7:0]          sy1_r, sy2_r, sy3_r, pin_r;
   logic [1:0]          init_cnt_r, clr_ph_r;
   logic [3:0]          cfg_err_r;
   logic [1:0]          hold_sel_r;
   logic                nvm_err_r, restart_q_r, blink_r;
   logic [24:0]         blink_cnt_r;
   logic [15:0]         alarm_r, alarm_nxt, status_r, base_r, addr_r;
   aas_pkg::aas_word4_t in_r, out_r, in_nxt, out_nxt;
   logic                erc_r, erh_r, adj_lamp_r, run_lamp_r, conv_run_r;

   function automatic logic bcd_ok(input logic [15:0] v);
      logic ok;
      ok = 1'b1;
      for (int i = 0; i < 4; i++) begin
         if (v[i*4 +: 4] > aas_pkg::BCD_DIGIT_MAX) begin
            ok = 1'b0;
         end
      end
      return ok;
   endfunction

   // pin synchroniser, value accepted once stages two and three agree
   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         sy1_r <= 8'h00;
         sy2_r <= 8'h00;
         sy3_r <= 8'h00;
         pin_r <= 8'h00;
      end else begin
         sy1_r <= {adj_switch_pin_i, unit_no_pin_i};
         sy2_r <= sy1_r;
         sy3_r <= sy2_r;
         if (sy2_r == sy3_r) begin
            pin_r <= sy3_r;
         end
      end
   end

   wire [6:0] unit_no   = pin_r[6:0];
   wire       adj_sw    = pin_r[7];
   wire       pin_settled = (sy2_r == sy3_r) && (pin_r == sy3_r);
   wire       init_done = (init_cnt_r == aas_pkg::INIT_WAIT) && pin_settled;
   wire       unit_bad  = dup_unit_i || (unit_no > aas_pkg::UNIT_MAX);
   wire [3:0] cfg_chk = {
      init_cfg_i.avg_set > aas_pkg::AVG_SET_MAX,
      init_cfg_i.hold_set > aas_pkg::HOLD_SET_MAX,
      !bcd_ok(init_cfg_i.ratio_set),
      init_cfg_i.ratio_unused};
   wire       restart_fall = restart_q_r && !restart_i;
   wire       flt_any  = |host_flt_i;

   // adjustment channel decode: 11-14 inputs, 21-24 outputs
   wire [3:0] ch_grp = adj_ch_i[7:4];
   wire [3:0] ch_num = adj_ch_i[3:0];
   wire [1:0] ch_idx = 2'(ch_num - aas_pkg::CH_IDX_MIN);
   wire       ch_num_ok = (ch_num >= aas_pkg::CH_IDX_MIN) &&
                          (ch_num <= aas_pkg::CH_IDX_MAX);
   wire       ch_ok = ch_num_ok &&
                      (((ch_grp == aas_pkg::CH_GRP_IN) && in_used_i[ch_idx]) ||
                       ((ch_grp == aas_pkg::CH_GRP_OUT) && out_used_i[ch_idx]));
   wire       in_adj  = (st_r == aas_pkg::ST_ADJ);
   wire [3:0] disc_live = disc_i & range_1to5_i;

   // mode sequencing
   always_comb begin
      st_nxt = st_r;
      case (st_r)
         aas_pkg::ST_INIT: begin
            if (init_done) begin
               if (unit_bad) begin
                  st_nxt = aas_pkg::ST_UNIT_ERR;
               end else if (adj_sw) begin
                  st_nxt = aas_pkg::ST_ADJ;
               end else if (|cfg_chk) begin
                  st_nxt = aas_pkg::ST_CFG_ERR;
               end else begin
                  st_nxt = aas_pkg::ST_RUN;
               end
            end
         end
         aas_pkg::ST_ADJ: begin
            if (host_run_i) begin
               st_nxt = aas_pkg::ST_ADJ_PLC;
            end
         end
         aas_pkg::ST_RESTART: begin
            if (restart_fall) begin
               st_nxt = aas_pkg::ST_INIT;
            end
         end
         aas_pkg::ST_RUN, aas_pkg::ST_CFG_ERR, aas_pkg::ST_UNIT_ERR,
         aas_pkg::ST_ADJ_PLC: begin
            st_nxt = st_r;
         end
         default: begin
            st_nxt = aas_pkg::ST_INIT;
         end
      endcase
      if (restart_i) begin
         st_nxt = aas_pkg::ST_RESTART;
      end
   end

   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         st_r        <= aas_pkg::ST_INIT;
         init_cnt_r  <= 2'h0;
         restart_q_r <= 1'b0;
      end else begin
         st_r        <= st_nxt;
         restart_q_r <= restart_i;
         if (st_r != aas_pkg::ST_INIT) begin
            init_cnt_r <= 2'h0;
         end else if (init_cnt_r != aas_pkg::INIT_WAIT) begin
            init_cnt_r <= init_cnt_r + 2'h1;
         end
      end
   end

   // settings latched at start, cleared only by a fresh start
   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         cfg_err_r  <= 4'h0;
         hold_sel_r <= aas_pkg::HOLD_ZERO;
         base_r     <= 16'h0000;
         addr_r     <= 16'h0000;
      end else if (st_r == aas_pkg::ST_INIT && init_done) begin
         cfg_err_r  <= cfg_chk;
         hold_sel_r <= init_cfg_i.hold_set[1:0];
         base_r     <= 16'(aas_pkg::BLOCK_BASE +
                           16'(unit_no) * aas_pkg::BLOCK_STRIDE);
         addr_r     <= 16'(aas_pkg::BLOCK_BASE + aas_pkg::ALARM_OFS +
                           16'(unit_no) * aas_pkg::BLOCK_STRIDE);
      end
   end

   // nvm fault: set wins, cleared after commit off, on, off
   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         nvm_err_r <= 1'b0;
         clr_ph_r  <= 2'h0;
      end else if (in_adj && nvm_fail_i) begin
         nvm_err_r <= 1'b1;
         clr_ph_r  <= 2'h0;
      end else if (!in_adj && st_r != aas_pkg::ST_ADJ_PLC) begin
         nvm_err_r <= 1'b0;
         clr_ph_r  <= 2'h0;
      end else if (nvm_err_r) begin
         case (clr_ph_r)
            2'h0: clr_ph_r <= commit_i ? 2'h0 : 2'h1;
            2'h1: clr_ph_r <= commit_i ? 2'h2 : 2'h1;
            default: begin
               if (!commit_i) begin
                  nvm_err_r <= 1'b0;
                  clr_ph_r  <= 2'h0;
               end
            end
         endcase
      end
   end

   // alarm word assembly
   always_comb begin
      alarm_nxt = aas_pkg::ALARM_RESET;
      case (st_r)
         aas_pkg::ST_RUN: begin
            alarm_nxt[aas_pkg::OUT_FLAG_LSB +: 4] =
               out_range_err_i;
            alarm_nxt[aas_pkg::DISC_FLAG_LSB +: 4] = disc_live;
         end
         aas_pkg::ST_CFG_ERR: begin
            alarm_nxt[aas_pkg::RATIO_USE_BIT +: 4] = cfg_err_r;
         end
         aas_pkg::ST_ADJ: begin
            alarm_nxt[aas_pkg::ADJ_MODE_BIT]  = 1'b1;
            alarm_nxt[aas_pkg::NVM_FAIL_BIT]  = nvm_err_r || nvm_fail_i;
            alarm_nxt[aas_pkg::ADJ_CHAN_BIT]  = !ch_ok;
            alarm_nxt[aas_pkg::ADJ_RANGE_BIT] = adj_range_err_i;
         end
         aas_pkg::ST_ADJ_PLC: begin
            alarm_nxt = aas_pkg::ALARM_PLC_ONLY;
         end
         default: begin
            alarm_nxt = aas_pkg::ALARM_RESET;
         end
      endcase
   end

   // per-channel input and output selection
   for (genvar k = 0; k < 4; k++) begin : g_ch
      wire [15:0] held_out =
         (hold_sel_r == aas_pkg::HOLD_LAST) ? out_r[k] :
         (hold_sel_r == aas_pkg::HOLD_FULL) ? aas_pkg::OUT_FULL :
         aas_pkg::DATA_ZERO;
      wire run_st = (st_r == aas_pkg::ST_RUN);
      wire freeze = (st_r == aas_pkg::ST_ADJ_PLC) ||
                    (run_st && host_flt_i.mon_timeout) ||
                    (in_adj && !ch_ok);
      wire in_zero = (st_r == aas_pkg::ST_INIT) ||
                     (st_r == aas_pkg::ST_UNIT_ERR) ||
                     (st_r == aas_pkg::ST_CFG_ERR) ||
                     (run_st && host_flt_i.bus_err) ||
                     (run_st && disc_live[k]);
      wire out_zero = (st_r == aas_pkg::ST_INIT) ||
                      (st_r == aas_pkg::ST_RESTART) ||
                      (st_r == aas_pkg::ST_UNIT_ERR) ||
                      (st_r == aas_pkg::ST_CFG_ERR);
      wire out_hold_fn = run_st && (host_flt_i.bus_err ||
                         host_flt_i.watchdog ||
                         out_range_err_i[k]);
      wire in_keep = freeze || (st_r == aas_pkg::ST_RESTART) ||
                     (run_st && host_flt_i.watchdog);
      wire out_keep = freeze ||
                      (in_adj && (nvm_err_r || nvm_fail_i));
      assign in_nxt[k] = in_keep ? in_r[k] :
                         in_zero ? aas_pkg::DATA_ZERO : conv_data_i[k];
      assign out_nxt[k] = out_zero ? aas_pkg::DATA_ZERO :
                          out_keep ? out_r[k] :
                          out_hold_fn ? held_out : out_set_i[k];
   end

   wire blink_wrap = (blink_cnt_r == 25'(BLINK_CYC - 1));
   wire adj_any    = in_adj || (st_r == aas_pkg::ST_ADJ_PLC);

   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         alarm_r     <= aas_pkg::ALARM_RESET;
         status_r    <= aas_pkg::ALARM_RESET;
         in_r        <= '0;
         out_r       <= '0;
         blink_cnt_r <= 25'h000_0000;
         blink_r     <= 1'b0;
         erc_r       <= 1'b0;
         erh_r       <= 1'b0;
         adj_lamp_r  <= 1'b0;
         run_lamp_r  <= 1'b0;
         conv_run_r  <= 1'b0;
      end else begin
         alarm_r <= alarm_nxt;
         if (io_refresh_i) begin
            status_r <= alarm_r;
         end
         in_r  <= in_nxt;
         out_r <= out_nxt;
         blink_cnt_r <= (blink_wrap || !adj_any) ? 25'h000_0000 :
                        blink_cnt_r + 25'h000_0001;
         blink_r    <= adj_any && (blink_wrap ? !blink_r : blink_r);
         adj_lamp_r <= adj_any && blink_r;
         erc_r      <= (|alarm_nxt[14:0]) ||
                       (st_r == aas_pkg::ST_ADJ_PLC);
         erh_r      <= (st_r == aas_pkg::ST_UNIT_ERR) ||
                       ((st_r == aas_pkg::ST_RUN) && flt_any);
         run_lamp_r <= (st_r == aas_pkg::ST_RUN) || adj_any;
         conv_run_r <= (st_r == aas_pkg::ST_RUN) || in_adj;
      end
   end

   assign alarm_status_word_o = status_r;
   assign word_base_o         = base_r;
   assign alarm_addr_o        = addr_r;
   assign in_data_o           = in_r;
   assign out_value_o         = out_r;
   assign conv_run_o          = conv_run_r;
   assign unit_error_lamp_o   = erc_r;
   assign host_error_lamp_o   = erh_r;
   assign adjust_lamp_o       = adj_lamp_r;
   assign run_lamp_o          = run_lamp_r;

   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!rstn_i);

   disc_zero_a: assert property (
      $past(st_r == aas_pkg::ST_RUN && !flt_any && disc_i[0] &&
            range_1to5_i[0]) |-> alarm_r[4] && in_r[0] == 16'h0000)
      else $error("disconnected input not zeroed");
   range_gate_a: assert property (!range_1to5_i[1] |=> !alarm_r[5])
      else $error("disconnection flag outside 1-5 V range");
   self_clear_a: assert property (
      st_r == aas_pkg::ST_RUN && !out_range_err_i[0] |=> !alarm_r[0])
      else $error("output flag did not clear");
   adj_flag_a: assert property (in_adj |=> alarm_r[15])
      else $error("adjust indicator missing");
   plc_only_a: assert property (
      st_r == aas_pkg::ST_ADJ_PLC |=> alarm_r == 16'h8000 &&
      out_r == $past(out_r) && in_r == $past(in_r))
      else $error("host run during adjustment not frozen");
   nvm_set_a: assert property (in_adj && nvm_fail_i |=> nvm_err_r)
      else $error("nvm fault lost");
   nvm_clear_a: assert property (
      $fell(nvm_err_r) && $past(in_adj) |-> $past(clr_ph_r) == 2'h2 &&
      !$past(commit_i))
      else $error("nvm fault cleared early");
   chan_hold_a: assert property (
      in_adj && !ch_ok && !host_run_i && !restart_i |=>
      alarm_r[13] && out_r == $past(out_r))
      else $error("bad channel changed data");
   cfg_sticky_a: assert property (
      st_r == aas_pkg::ST_CFG_ERR && !restart_i |=>
      st_r == aas_pkg::ST_CFG_ERR && !run_lamp_r)
      else $error("setting error left without restart");
   restart_zero_a: assert property (
      st_r == aas_pkg::ST_RESTART |=> out_r == '0 && in_r == $past(in_r))
      else $error("restart outputs not zero");
   unit_err_a: assert property (
      st_r == aas_pkg::ST_UNIT_ERR |=> in_r == '0 && out_r == '0 &&
      !conv_run_r)
      else $error("unit number error outputs wrong");
   refresh_a: assert property (
      io_refresh_i |=> status_r == $past(alarm_r))
      else $error("alarm word not refreshed");
endmodule

// ===== tb/aas_host_model.sv
`timescale 1ns/10ps
module aas_host_model (
   // clock
   input  wire logic core_clk_i,
   // host control
   output logic      io_refresh_o,
   output logic      restart_o,
   output logic      commit_o,
   output logic      host_run_o
);
   initial begin
      io_refresh_o = 1'b0;
      restart_o    = 1'b0;
      commit_o     = 1'b0;
      host_run_o   = 1'b0;
   end
   // one refresh pulse publishes the status word
   task automatic refresh();
      @(posedge core_clk_i) io_refresh_o <= 1'b1;
      @(posedge core_clk_i) io_refresh_o <= 1'b0;
   endtask
   task automatic set_restart(input logic v);
      @(posedge core_clk_i) restart_o <= v;
   endtask
   task automatic set_run(input logic v);
      @(posedge core_clk_i) host_run_o <= v;
   endtask
   // commit bit off, on, off again clears a memory fault
   task automatic commit_cycle();
      @(posedge core_clk_i) commit_o <= 1'b1;
      @(posedge core_clk_i) commit_o <= 1'b1;
      @(posedge core_clk_i) commit_o <= 1'b0;
      @(posedge core_clk_i) commit_o <= 1'b0;
   endtask
endmodule

// ===== tb/tb.sv
`timescale 1ns/10ps
module tb;
   logic core_clk_i, rstn_i, adj_switch_pin_i, io_refresh_i, restart_i;
   logic host_run_i, commit_i, dup_unit_i, adj_range_err_i, nvm_fail_i;
   logic [6:0] unit_no_pin_i;
   logic [7:0] adj_ch_i;
   logic [3:0] in_used_i, out_used_i, range_1to5_i, disc_i, out_range_err_i;
   aas_pkg::aas_host_flt_t host_flt_i;
   aas_pkg::aas_init_cfg_t init_cfg_i, bad [4];
   aas_pkg::aas_word4_t    conv_data_i, out_set_i, in_data_o, out_value_o;
   logic [15:0] alarm_status_word_o, word_base_o, alarm_addr_o;
   logic conv_run_o, unit_error_lamp_o, host_error_lamp_o;
   logic adjust_lamp_o, run_lamp_o, seen_hi, seen_lo;
   int   err_count, checked;
   localparam aas_pkg::aas_init_cfg_t GOOD = '{1'b0, 16'h9999, 16'h0002,
                                               16'h0006};
   localparam logic [63:0] C0 = 64'h0444_0333_0222_0111;
   localparam logic [63:0] C1 = 64'h0888_0777_0666_0555;
   localparam logic [15:0] FS = aas_pkg::OUT_FULL;

   aas_top #(.BLINK_CYC(4)) dut (.core_clk_i, .rstn_i, .unit_no_pin_i,
      .adj_switch_pin_i, .io_refresh_i, .restart_i, .host_run_i, .commit_i,
      .dup_unit_i, .host_flt_i, .init_cfg_i, .in_used_i, .out_used_i,
      .range_1to5_i, .disc_i, .out_range_err_i, .conv_data_i, .out_set_i,
      .adj_ch_i, .adj_range_err_i, .nvm_fail_i, .alarm_status_word_o,
      .word_base_o, .alarm_addr_o, .in_data_o, .out_value_o, .conv_run_o,
      .unit_error_lamp_o, .host_error_lamp_o, .adjust_lamp_o, .run_lamp_o);
   aas_host_model host (.core_clk_i, .io_refresh_o(io_refresh_i),
      .restart_o(restart_i), .commit_o(commit_i), .host_run_o(host_run_i));

   initial begin
      core_clk_i = 1'b0;
      forever #5 core_clk_i = ~core_clk_i;
   end

   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk_i);
   endtask
   task automatic chk(input logic [63:0] g, input logic [63:0] e);
      checked++;
      if (g !== e) begin
         $display("wrong value at %0t: got %h want %h", $time, g, e);
         err_count++;
      end
   endtask
   // read the status word through one refresh cycle
   task automatic rd(input logic [15:0] e);
      cyc(3);
      host.refresh();
      #1;
      chk(64'(alarm_status_word_o), 64'(e));
   endtask
   task automatic restart();
      host.set_restart(1'b1);
      cyc(3);
      #1;
      chk(out_value_o, 64'h0);
      host.set_restart(1'b0);
      cyc(12);
   endtask
   task automatic end_of_test();
      $display("mismatches %0d checks %0d", err_count, checked);
      if (err_count == 0 && checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   initial begin
      cyc(20000);
      err_count++;
      end_of_test();
   end

   initial begin
      err_count = 0;
      checked = 0;
      rstn_i = 1'b0;
      unit_no_pin_i = 7'h05;
      {adj_switch_pin_i, dup_unit_i, adj_range_err_i, nvm_fail_i} = 4'h0;
      adj_ch_i = 8'h11;
      {in_used_i, out_used_i} = 8'hFF;
      {range_1to5_i, disc_i, out_range_err_i} = 12'h000;
      host_flt_i = '0;
      init_cfg_i = GOOD;
      conv_data_i = C0;
      out_set_i = C1;
      bad[0] = '{1'b1, 16'h9999, 16'h0002, 16'h0006};
      bad[1] = '{1'b0, 16'h99A9, 16'h0002, 16'h0006};
      bad[2] = '{1'b0, 16'h9999, 16'h0003, 16'h0006};
      bad[3] = '{1'b0, 16'h9999, 16'h0002, 16'h0007};
      cyc(20);
      @(posedge core_clk_i) rstn_i <= 1'b1;
      cyc(12);
      chk(64'(word_base_o), 64'h0802);
      chk(64'(alarm_addr_o), 64'h080B);
      rd(16'h0000);
      chk(64'(run_lamp_o & conv_run_o), 64'h1);
      @(posedge core_clk_i) {range_1to5_i, disc_i} <= 8'h13;
      rd(16'h0010);
      chk(in_data_o, {C0[63:16], 16'h0});
      chk(64'(unit_error_lamp_o), 64'h1);
      @(posedge core_clk_i) disc_i <= 4'h0;
      rd(16'h0000);
      chk(64'(unit_error_lamp_o), 64'h0);
      @(posedge core_clk_i) out_range_err_i <= 4'h4;
      rd(16'h0004);
      chk(out_value_o, {C1[63:48], FS, C1[31:0]});
      @(posedge core_clk_i) out_range_err_i <= 4'h0;
      @(posedge core_clk_i) host_flt_i <= '{1'b1, 1'b0, 1'b0};
      cyc(4);
      chk(64'(host_error_lamp_o), 64'h1);
      chk(in_data_o, 64'h0);
      chk(out_value_o, {4{FS}});
      @(posedge core_clk_i) host_flt_i <= '0;
      cyc(4);
      chk(in_data_o, C0);
      @(posedge core_clk_i) host_flt_i <= '{1'b0, 1'b1, 1'b0};
      cyc(4);
      @(posedge core_clk_i) {conv_data_i, out_set_i} <= {C1, C0};
      cyc(4);
      chk(in_data_o, C0);
      chk(out_value_o, C1);
      @(posedge core_clk_i) host_flt_i <= '{1'b0, 1'b0, 1'b1};
      cyc(4);
      chk(out_value_o, {4{FS}});
      @(posedge core_clk_i) host_flt_i <= '0;
      cyc(4);
      chk(in_data_o, C1);
      @(posedge core_clk_i) init_cfg_i <= '{1'b0, 16'h0, 16'h1, 16'h0};
      restart();
      @(posedge core_clk_i) {out_range_err_i, out_set_i} <= {4'h1, C1};
      cyc(4);
      chk(out_value_o, {C1[63:16], C0[15:0]});
      @(posedge core_clk_i) out_range_err_i <= 4'h0;
      for (int i = 0; i < 4; i++) begin
         @(posedge core_clk_i) init_cfg_i <= bad[i];
         restart();
         rd(16'h0100 << i);
         chk(64'({run_lamp_o, unit_error_lamp_o, conv_run_o}),
             64'h2);
         chk(in_data_o, 64'h0);
         @(posedge core_clk_i) init_cfg_i <= GOOD;
         rd(16'h0100 << i);
         restart();
         rd(16'h0000);
      end
      @(posedge core_clk_i) unit_no_pin_i <= 7'h60;
      restart();
      chk(64'({run_lamp_o, host_error_lamp_o, conv_run_o}),
          64'h2);
      chk(64'({in_data_o, out_value_o} != 128'h0), 64'h0);
      @(posedge core_clk_i) {unit_no_pin_i, dup_unit_i} <= {7'h05, 1'b1};
      restart();
      chk(64'({host_error_lamp_o, conv_run_o}), 64'h2);
      @(posedge core_clk_i) {unit_no_pin_i, dup_unit_i} <= {7'h5F, 1'b0};
      restart();
      chk(64'({word_base_o, alarm_addr_o}), 64'h0B86_0B8F);
      @(posedge core_clk_i) adj_switch_pin_i <= 1'b1;
      restart();
      rd(16'h8000);
      {seen_hi, seen_lo} = 2'b00;
      repeat (20) begin
         @(negedge core_clk_i);
         seen_hi |= (adjust_lamp_o === 1'b1);
         seen_lo |= (adjust_lamp_o === 1'b0);
      end
      chk(64'({seen_hi, seen_lo}), 64'h3);
      @(posedge core_clk_i) adj_ch_i <= 8'h31;
      rd(16'hA000);
      @(posedge core_clk_i) adj_ch_i <= 8'h24;
      rd(16'h8000);
      @(posedge core_clk_i) adj_range_err_i <= 1'b1;
      rd(16'h9000);
      chk(in_data_o, C1);
      @(posedge core_clk_i) adj_range_err_i <= 1'b0;
      @(posedge core_clk_i) {nvm_fail_i, out_set_i} <= {1'b1, C0};
      @(posedge core_clk_i) nvm_fail_i <= 1'b0;
      rd(16'hC000);
      chk(out_value_o, C1);
      host.commit_cycle();
      rd(16'h8000);
      chk(out_value_o, C0);
      @(posedge core_clk_i) adj_range_err_i <= 1'b1;
      host.set_run(1'b1);
      @(posedge core_clk_i) conv_data_i <= C0;
      rd(16'h8000);
      chk(in_data_o, C1);
      chk(64'(unit_error_lamp_o), 64'h1);
      host.set_run(1'b0);
      @(posedge core_clk_i) {adj_switch_pin_i, adj_range_err_i} <= 2'b00;
      restart();
      rd(16'h0000);
      chk(64'(run_lamp_o), 64'h1);
      end_of_test();
   end
endmodule
